// ===== logic/dtc_top.sv
// Two timer/counters with external interrupt request flags.
// Assumes a core that pulses a vector acknowledge per interrupt source
// and a register master that never issues read and write together.
//
// Functional notes
// RQ1 - Timer 1 overflow sets control bit 7; vectoring clears it.
// RQ2 - Control bit 6 starts and stops timer 1.
// RQ3 - Timer 0 overflow sets control bit 5; vectoring clears it.
// RQ4 - Control bit 4 starts and stops timer 0.
// RQ5 - Bit 3 flags pin 1 edge or low; vector clears only edge.
// RQ6 - Bit 2: one picks falling edge, zero low level, for pin 1.
// RQ7 - Bit 1 flags pin 0 edge or low; vector clears only edge.
// RQ8 - Bit 0: one picks falling edge, zero low level, for pin 0.
// RQ9 - Level mode flag follows the pin; source releases the request.
// RQ10 - Each timer is a high and a low byte, joined per mode.
// RQ11 - Mode 0 counts 13 bits: high byte and five low bits.
// RQ12 - Wrap from all ones to zero sets the overflow flag.
// RQ13 - Counting needs run bit and either gate off or pin high.
// RQ14 - Setting run leaves the count registers untouched.
// RQ15 - Mode 1 counts all sixteen bits.
// RQ16 - Mode 2 reloads low byte from high byte on overflow.
// RQ17 - Timer 1 in mode 3 holds its count.
// RQ18 - Timer 0 mode 3 low byte keeps all timer 0 controls.
// RQ19 - Timer 0 mode 3 high byte uses timer 1 run and flag.
// RQ20 - Then timer 1 runs unless in mode 3, raising no flag.
// RQ21 - Source select one counts pin edges, zero machine cycles.
// RQ22 - Gate zero ignores the interrupt pin.
// RQ23 - Two-bit mode field: 13-bit, 16-bit, reload, split.
// RQ24 - Count pin is synchronised; each falling edge counts once.
`include "dtc_defs.svh"

module dtc_top
	import dtc_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Vector acknowledges from the core
	input wire logic ACK_T0,
	input wire logic ACK_T1,
	input wire logic ACK_X0,
	input wire logic ACK_X1,
	// Pins
	input wire logic EXT_IRQ0_PIN,
	input wire logic EXT_IRQ1_PIN,
	input wire logic TIMER0_COUNT_PIN,
	input wire logic TIMER1_COUNT_PIN,
	// Flags to the interrupt controller
	output logic TIMER0_OVERFLOW_FLAG,
	output logic TIMER1_OVERFLOW_FLAG,
	output logic EXT_IRQ0_REQUEST_FLAG,
	output logic EXT_IRQ1_REQUEST_FLAG,
	// Timer 1 overflow pulse for baud use
	output logic T1_OVF_PULSE
);

	dtc_state_t st_r;
	dtc_state_t st_nxt;
	dtc_mode_t mode0;
	dtc_mode_t mode1;
	dtc_cnt_t step0;
	dtc_cnt_t step1;
	logic [3:0] settle;
	logic [3:0] fall;
	logic mcyc;
	logic t0m3;
	logic tr0;
	logic tr1;
	logic tick0;
	logic tick1;
	logic open0;
	logic open1;
	logic en0;
	logic en0h;
	logic en1;
	logic ovf0;
	logic ovf0h;
	logic ovf1;
	logic set_tf1;
	logic wr_ctrl;
	logic wr_mode;
	logic wr_t0lo;
	logic wr_t0hi;
	logic wr_t1lo;
	logic wr_t1hi;

	// One count step of a joined timer; split mode steps the low byte only
	function automatic dtc_cnt_t dtc_step(input dtc_mode_t m,
		input logic [7:0] lo, input logic [7:0] hi);
		dtc_cnt_t c;
		logic [13:0] w13;
		logic [16:0] w16;
		logic [8:0] w8;
		w13 = {1'b0, hi, lo[4:0]} + 14'h1;
		w16 = {1'b0, hi, lo} + 17'h1;
		w8 = {1'b0, lo} + 9'h1;
		c.ovf = 1'b0;
		c.lo = lo;
		c.hi = hi;
		unique case (m)
			DTC_M13: begin
				// Upper three low bits are left alone
				c.hi = w13[12:5]; // see RQ11
				c.lo = {lo[7:5], w13[4:0]}; // see RQ11
				c.ovf = w13[13]; // see RQ12
			end
			DTC_M16: begin
				c.hi = w16[15:8]; // see RQ15
				c.lo = w16[7:0]; // see RQ15
				c.ovf = w16[16]; // see RQ12
			end
			DTC_M8AR: begin
				c.ovf = w8[8]; // see RQ12
				c.lo = w8[8] ? hi : w8[7:0]; // see RQ16
			end
			DTC_MSPLIT: begin
				c.ovf = w8[8]; // see RQ18
				c.lo = w8[7:0]; // see RQ18
			end
		endcase
		return c;
	endfunction

	// Field decode of the mode and control registers
	assign mode0 = dtc_mode_t'(st_r.mode[`DTC_T0_NIB]); // see RQ23
	assign mode1 = dtc_mode_t'(st_r.mode[5:4]); // see RQ23
	assign t0m3 = (mode0 == DTC_MSPLIT);
	assign tr0 = st_r.ctrl[`DTC_B_TR0];
	assign tr1 = st_r.ctrl[`DTC_B_TR1];

	// A pin change counts once the second and third stages agree
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			settle[i] = (st_r.s2[i] == st_r.s3[i]);
			fall[i] = settle[i] & st_r.filt[i] & ~st_r.s2[i]; // see RQ24
		end
	end

	// Machine cycle enable from the clock divider
	assign mcyc = (st_r.div == (`DTC_MCYC_CLKS - 4'h1));

	// Count source and gating per timer
	assign tick0 = st_r.mode[`DTC_N_CT] ? fall[`DTC_P_CNT0] : mcyc; // see RQ21
	assign tick1 = st_r.mode[4 + `DTC_N_CT] ? fall[`DTC_P_CNT1] : mcyc; // see RQ21
	assign open0 = ~st_r.mode[`DTC_N_GATE] | st_r.filt[`DTC_P_EXT_IRQ0_PIN]; // see RQ22
	assign open1 = ~st_r.mode[4 + `DTC_N_GATE] | st_r.filt[`DTC_P_EXT_IRQ1_PIN]; // see RQ22
	assign en0 = tr0 & open0 & tick0; // see RQ4 RQ13
	// In split mode timer 1 loses its run bit and runs unless in mode 3
	assign en1 = (t0m3 | tr1) & open1 & tick1 &
		(mode1 != DTC_MSPLIT); // see RQ2
	assign en0h = t0m3 & tr1 & mcyc; // see RQ19

	// Count steps and overflow events
	assign step0 = dtc_step(mode0, st_r.t0lo, st_r.t0hi); // see RQ10
	assign step1 = dtc_step(mode1, st_r.t1lo, st_r.t1hi); // see RQ10
	assign ovf0 = en0 & step0.ovf;
	assign ovf0h = en0h & (st_r.t0hi == 8'hff);
	assign ovf1 = en1 & step1.ovf;
	assign set_tf1 = t0m3 ? ovf0h : ovf1; // see RQ20

	// Register write decode
	assign wr_ctrl = WR & (ADDR == `DTC_ADDR_CTRL);
	assign wr_mode = WR & (ADDR == `DTC_ADDR_MODE);
	assign wr_t0lo = WR & (ADDR == `DTC_ADDR_T0LO);
	assign wr_t0hi = WR & (ADDR == `DTC_ADDR_T0HI);
	assign wr_t1lo = WR & (ADDR == `DTC_ADDR_T1LO);
	assign wr_t1hi = WR & (ADDR == `DTC_ADDR_T1HI);

	// Next state; a bus write to a count byte beats the count step
	always_comb begin
		st_nxt = st_r;
		// Three-stage pin synchroniser and settled level
		st_nxt.s1 = {TIMER1_COUNT_PIN, TIMER0_COUNT_PIN,
			EXT_IRQ1_PIN, EXT_IRQ0_PIN};
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < 4; i++) begin
			if (settle[i]) begin
				st_nxt.filt[i] = st_r.s2[i];
			end
		end
		// Divider
		st_nxt.div = mcyc ? 4'h0 : st_r.div + 4'h1;
		// Timer 0 count
		if (en0) begin
			st_nxt.t0lo = step0.lo;
			if (!t0m3) begin
				st_nxt.t0hi = step0.hi;
			end
		end
		if (en0h) begin
			st_nxt.t0hi = st_r.t0hi + 8'h1; // see RQ19
		end
		// Timer 1 count; mode 3 holds since en1 stays low
		if (en1) begin
			st_nxt.t1lo = step1.lo; // see RQ17
			st_nxt.t1hi = step1.hi;
		end
		// Bus writes; run bit changes never touch the counts
		if (wr_t0lo) begin
			st_nxt.t0lo = WDATA; // see RQ14
		end
		if (wr_t0hi) begin
			st_nxt.t0hi = WDATA;
		end
		if (wr_t1lo) begin
			st_nxt.t1lo = WDATA;
		end
		if (wr_t1hi) begin
			st_nxt.t1hi = WDATA;
		end
		if (wr_mode) begin
			st_nxt.mode = WDATA;
		end
		if (wr_ctrl) begin
			st_nxt.ctrl = WDATA; // see RQ2
		end
		// Vector acknowledges clear flags
		if (ACK_T0) begin
			st_nxt.ctrl[`DTC_B_TF0] = 1'b0; // see RQ3
		end
		if (ACK_T1) begin
			st_nxt.ctrl[`DTC_B_TF1] = 1'b0; // see RQ1
		end
		if (ACK_X0 && st_r.ctrl[`DTC_B_IT0]) begin
			st_nxt.ctrl[`DTC_B_IE0] = 1'b0; // see RQ7
		end
		if (ACK_X1 && st_r.ctrl[`DTC_B_IT1]) begin
			st_nxt.ctrl[`DTC_B_IE1] = 1'b0; // see RQ5
		end
		// Hardware sets last so an event in a clear cycle is kept
		if (ovf0) begin
			st_nxt.ctrl[`DTC_B_TF0] = 1'b1; // see RQ3
		end
		if (set_tf1) begin
			st_nxt.ctrl[`DTC_B_TF1] = 1'b1; // see RQ1
		end
		// Edge mode latches a fall; level mode mirrors the pin
		if (st_r.ctrl[`DTC_B_IT0]) begin
			if (fall[`DTC_P_EXT_IRQ0_PIN]) begin
				st_nxt.ctrl[`DTC_B_IE0] = 1'b1; // see RQ8
			end
		end else begin
			st_nxt.ctrl[`DTC_B_IE0] = ~st_r.filt[`DTC_P_EXT_IRQ0_PIN]; // see RQ9
		end
		if (st_r.ctrl[`DTC_B_IT1]) begin
			if (fall[`DTC_P_EXT_IRQ1_PIN]) begin
				st_nxt.ctrl[`DTC_B_IE1] = 1'b1; // see RQ6
			end
		end else begin
			st_nxt.ctrl[`DTC_B_IE1] = ~st_r.filt[`DTC_P_EXT_IRQ1_PIN]; // see RQ9
		end
		// Baud pulse keeps running even when the flag goes to timer 0
		st_nxt.t1_ovf = ovf1; // see RQ20
		// Read data stand one cycle; unmapped reads give zero
		st_nxt.rdata = 8'h00;
		if (RD) begin
			unique case (ADDR)
				`DTC_ADDR_CTRL: st_nxt.rdata = st_r.ctrl;
				`DTC_ADDR_MODE: st_nxt.rdata = st_r.mode;
				`DTC_ADDR_T0LO: st_nxt.rdata = st_r.t0lo;
				`DTC_ADDR_T0HI: st_nxt.rdata = st_r.t0hi;
				`DTC_ADDR_T1LO: st_nxt.rdata = st_r.t1lo;
				`DTC_ADDR_T1HI: st_nxt.rdata = st_r.t1hi;
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// State register; pins idle high so the synchroniser starts high
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_r <= '0;
			st_r.s1 <= 4'hf;
			st_r.s2 <= 4'hf;
			st_r.s3 <= 4'hf;
			st_r.filt <= 4'hf;
			st_r.ctrl <= `DTC_CTRL_RST;
			st_r.mode <= `DTC_MODE_RST;
			st_r.t0lo <= `DTC_CNT_RST;
			st_r.t0hi <= `DTC_CNT_RST;
			st_r.t1lo <= `DTC_CNT_RST;
			st_r.t1hi <= `DTC_CNT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign RDATA = st_r.rdata;
	assign TIMER0_OVERFLOW_FLAG = st_r.ctrl[`DTC_B_TF0];
	assign TIMER1_OVERFLOW_FLAG = st_r.ctrl[`DTC_B_TF1];
	assign EXT_IRQ0_REQUEST_FLAG = st_r.ctrl[`DTC_B_IE0];
	assign EXT_IRQ1_REQUEST_FLAG = st_r.ctrl[`DTC_B_IE1];
	assign T1_OVF_PULSE = st_r.t1_ovf;

	// Checks on the design's own behaviour
	default clocking dtc_cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	// An overflow always lands in the flag, even against an acknowledge
	AST_TF0_SET: assert property ( // see RQ3
		ovf0 |=> st_r.ctrl[`DTC_B_TF0])
		else $error("timer 0 overflow lost");

	AST_TF0_ACK: assert property ( // see RQ3
		ACK_T0 && !ovf0 && !wr_ctrl |=> !st_r.ctrl[`DTC_B_TF0])
		else $error("timer 0 flag not cleared by acknowledge");

	// Edge requests drop on the vector unless a new fall arrives
	AST_IE0_ACK: assert property ( // see RQ7
		ACK_X0 && st_r.ctrl[`DTC_B_IT0] && !fall[`DTC_P_EXT_IRQ0_PIN] && !wr_ctrl
		|=> !st_r.ctrl[`DTC_B_IE0])
		else $error("edge request 0 not cleared by acknowledge");

	// With the gate off a running 16-bit count steps whatever the pin
	AST_GATE_OFF: assert property ( // see RQ22
		!st_r.mode[`DTC_N_GATE] && tr0 && tick0 && !WR && mode0 == DTC_M16
		|=> {st_r.t0hi, st_r.t0lo} ==
		16'($past({st_r.t0hi, st_r.t0lo}) + 16'h1))
		else $error("timer 0 did not count with gate off");

	AST_TF1_ACK: assert property ( // see RQ1
		ACK_T1 && !set_tf1 && !wr_ctrl |=> !st_r.ctrl[`DTC_B_TF1])
		else $error("timer 1 flag not cleared by acknowledge");

	AST_RUN_OFF: assert property ( // see RQ4
		!tr0 && !WR |=> $stable(st_r.t0lo))
		else $error("timer 0 low byte moved while stopped");

	AST_GATE_SHUT: assert property ( // see RQ13
		st_r.mode[`DTC_N_GATE] && !st_r.filt[`DTC_P_EXT_IRQ0_PIN] && !WR
		|=> $stable(st_r.t0lo))
		else $error("timer 0 counted with gate shut");

	AST_LEVEL: assert property ( // see RQ9
		!st_r.ctrl[`DTC_B_IT0]
		|=> st_r.ctrl[`DTC_B_IE0] == !$past(st_r.filt[`DTC_P_EXT_IRQ0_PIN]))
		else $error("level request does not follow the pin");

	AST_EDGE: assert property ( // see RQ5
		st_r.ctrl[`DTC_B_IT1] && fall[`DTC_P_EXT_IRQ1_PIN]
		|=> st_r.ctrl[`DTC_B_IE1])
		else $error("falling edge on pin 1 not flagged");

	AST_RELOAD: assert property ( // see RQ16
		mode0 == DTC_M8AR && ovf0 && !WR
		|=> st_r.t0lo == $past(st_r.t0hi) && $stable(st_r.t0hi))
		else $error("mode 2 reload wrong");

	AST_T1_HOLD: assert property ( // see RQ17
		mode1 == DTC_MSPLIT && !WR
		|=> $stable(st_r.t1lo) && $stable(st_r.t1hi))
		else $error("timer 1 moved in mode 3");

	AST_M13_TOP: assert property ( // see RQ11
		mode0 == DTC_M13 && !WR |=> $stable(st_r.t0lo[7:5]))
		else $error("mode 0 touched upper low bits");

	AST_SPLIT_HI: assert property ( // see RQ19
		t0m3 && st_r.t0hi == 8'hff && tr1 && mcyc && !WR
		|=> st_r.t0hi == 8'h00 && st_r.ctrl[`DTC_B_TF1])
		else $error("split high byte overflow wrong");

	AST_MCYC: assert property ( // see RQ21
		mcyc |=> !mcyc [*8])
		else $error("machine cycle enable too frequent");

	AST_RDATA: assert property (
		RD && ADDR == `DTC_ADDR_CTRL
		|=> RDATA == $past(st_r.ctrl) ##1 RDATA == 8'h00 || $past(RD))
		else $error("control read data wrong");

endmodule

// ===== logic/dtc_defs.svh
// Offsets, field positions, reset values and counts of the timer block.
// Assumes an 8-bit register port that decodes the full 8-bit address.
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
// Register addresses
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_T0LO 8'h8a
`define DTC_ADDR_T1LO 8'h8b
`define DTC_ADDR_T0HI 8'h8c
`define DTC_ADDR_T1HI 8'h8d
// Reset values
`define DTC_CTRL_RST 8'h00
`define DTC_MODE_RST 8'h00
`define DTC_CNT_RST 8'h00
// Control register bit positions
`define DTC_B_TF1 7
`define DTC_B_TR1 6
`define DTC_B_TF0 5
`define DTC_B_TR0 4
`define DTC_B_IE1 3
`define DTC_B_IT1 2
`define DTC_B_IE0 1
`define DTC_B_IT0 0
// Mode register: one nibble per timer
`define DTC_T0_NIB 3:0
`define DTC_T1_NIB 7:4
`define DTC_N_GATE 3
`define DTC_N_CT 2
`define DTC_N_SEL 1:0
// Synchronised pin indices
`define DTC_P_EXT_IRQ0_PIN 0
`define DTC_P_EXT_IRQ1_PIN 1
`define DTC_P_CNT0 2
`define DTC_P_CNT1 3
// Core clocks per machine cycle
`define DTC_MCYC_CLKS 4'hc
`endif

// ===== logic/dtc_pkg.sv
// Types shared by the dual timer/counter block.
// Assumes dtc_defs.svh is included by the files that need the numbers.
package dtc_pkg;
	// Mode field values in order 00, 01, 10, 11
	typedef enum logic [1:0] {
		DTC_M13,
		DTC_M16,
		DTC_M8AR,
		DTC_MSPLIT
	} dtc_mode_t;
	// Result of one count step
	typedef struct packed {
		logic ovf;
		logic [7:0] lo;
		logic [7:0] hi;
	} dtc_cnt_t;
	// Whole state of the top module
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] filt;
		logic [3:0] div;
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [7:0] t0lo;
		logic [7:0] t0hi;
		logic [7:0] t1lo;
		logic [7:0] t1hi;
		logic [7:0] rdata;
		logic t1_ovf;
	} dtc_state_t;
endpackage

// ===== tb/dtc_pin_model.sv
// Far side of the timer block: interrupt request pins and count pins.
// Assumes the bench pulses tick for one cycle per count event.
module dtc_pin_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bench commands
	input wire logic [1:0] req,
	input wire logic [1:0] tick,
	// Pins, idle high as behind a pull-up
	output logic [1:0] irq_pin,
	output logic [1:0] cnt_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] low_r [2];
	// The source alone holds and releases a level request
	assign irq_pin = ~req;
	// Low pulses outlast the synchroniser so each fall is seen once
	always_ff @(posedge clk or negedge rstn) begin
		for (int i = 0; i < 2; i++) begin
			if (!rstn) begin
				low_r[i] <= 3'h0;
			end else if (tick[i]) begin
				low_r[i] <= 3'h5;
			end else if (low_r[i] != 3'h0) begin
				low_r[i] <= low_r[i] - 3'h1;
			end
		end
	end
	assign cnt_pin[0] = (low_r[0] == 3'h0);
	assign cnt_pin[1] = (low_r[1] == 3'h0);
endmodule

// ===== tb/dtc_top_tb.sv
// Self-checking bench for the dual timer block over its register port.
// Assumes a 12-clock machine cycle and registered flags as handed over.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	fail_count++; $display("wrong value at %0t: got %h exp %h", \
	$time, g, e); end end
module dtc_top_tb;
	import dtc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, wr, rd;
	logic [7:0] addr, wdata, rdata, d;
	logic [3:0] ack, flg;
	logic [1:0] req, tick, irq_pin, cnt_pin;
	int fail_count = 0;
	int checks_done = 0;
	logic t1p;
	int ovf_pulses = 0;
	dtc_top i_dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .ACK_T0(ack[0]),
		.ACK_T1(ack[1]), .ACK_X0(ack[2]), .ACK_X1(ack[3]),
		.EXT_IRQ0_PIN(irq_pin[0]), .EXT_IRQ1_PIN(irq_pin[1]),
		.TIMER0_COUNT_PIN(cnt_pin[0]), .TIMER1_COUNT_PIN(cnt_pin[1]),
		.TIMER0_OVERFLOW_FLAG(flg[0]), .TIMER1_OVERFLOW_FLAG(flg[1]),
		.EXT_IRQ0_REQUEST_FLAG(flg[2]), .EXT_IRQ1_REQUEST_FLAG(flg[3]),
		.T1_OVF_PULSE(t1p));
	dtc_pin_model i_pins (.clk(clk), .rstn(rstn), .req(req), .tick(tick),
		.irq_pin(irq_pin), .cnt_pin(cnt_pin));
	// Count baud pulses; only the mode 2 wrap of timer 1 should make one
	always @(posedge clk) begin
		if (t1p === 1'b1) begin
			ovf_pulses++;
		end
	end
	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Register write, one strobe cycle
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
		@(posedge clk) wr <= 1'b0;
	endtask
	// Register read; data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) begin addr <= a; rd <= 1'b1; end
		@(posedge clk) rd <= 1'b0;
		#1 d = rdata;
		`CHK(d, e)
	endtask
	// Bounded wait for a flag to reach a level, then compare it
	task automatic wait_flag(input int b, input logic v);
		for (int n = 0; n < 40 && flg[b] !== v; n++) @(posedge clk);
		`CHK(flg[b], v)
	endtask
	task automatic pulse_ack(input int b);
		@(posedge clk) ack <= 4'h1 << b;
		@(posedge clk) ack <= 4'h0;
		repeat (2) @(posedge clk);
	endtask
	// One overflow step, then stop with the flag kept and read the bytes
	task automatic ovf(input int t, input logic [7:0] md, input logic [7:0] hi,
		input logic [7:0] lo, input logic [7:0] eh, input logic [7:0] el);
		wr_reg(8'h89, md);
		wr_reg(8'h8c + 8'(t), hi);
		wr_reg(8'h8a + 8'(t), lo);
		wr_reg(8'h88, t ? 8'h40 : 8'h10);
		wait_flag(t, 1'b1);
		wr_reg(8'h88, t ? 8'h80 : 8'h20);
		rd_chk(8'h8c + 8'(t), eh);
		rd_chk(8'h8a + 8'(t), el);
		pulse_ack(t);
		`CHK(flg[t], 1'b0)
	endtask
	task automatic results;
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run of some 330 cycles
	initial begin
		#200000;
		fail_count++;
		results();
	end
	initial begin
		{rstn, wr, rd, addr, wdata, ack, req, tick} = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		// Reset values, unmapped address reads zero
		for (int a = 8'h88; a < 8'h8f; a++) rd_chk(8'(a), 8'h00);
		// Gate closed by a low pin: no counting, preload kept
		wr_reg(8'h89, 8'h09);
		req <= 2'b01;
		wr_reg(8'h8a, 8'h55);
		wr_reg(8'h88, 8'h10);
		repeat (40) @(posedge clk);
		rd_chk(8'h8a, 8'h55);
		@(posedge clk) req <= 2'b00;
		repeat (40) @(posedge clk);
		rd_chk(8'h8a, 8'h58);
		// Modes 0, 1 and 2 each wrap in one step
		ovf(0, 8'h00, 8'hff, 8'hff, 8'h00, 8'he0);
		ovf(0, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00);
		ovf(1, 8'h20, 8'ha5, 8'hff, 8'ha5, 8'ha5);
		// Counter operation counts pin falls, not machine cycles
		wr_reg(8'h89, 8'h05);
		wr_reg(8'h8c, 8'h00);
		wr_reg(8'h8a, 8'h00);
		wr_reg(8'h88, 8'h10);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) tick <= 2'b01;
			@(posedge clk) tick <= 2'b00;
			repeat (10) @(posedge clk);
		end
		rd_chk(8'h8a, 8'h03);
		// Split mode: high byte of timer 0 drives the timer 1 flag
		wr_reg(8'h88, 8'h00);
		wr_reg(8'h89, 8'h33);
		wr_reg(8'h8b, 8'h77);
		wr_reg(8'h8c, 8'hff);
		wr_reg(8'h88, 8'h40);
		wait_flag(1, 1'b1);
		rd_chk(8'h8b, 8'h77);
		`CHK(ovf_pulses, 1)
		// External requests: edge mode clears on ack, level mode follows
		for (int i = 0; i < 2; i++) begin
			wr_reg(8'h88, 8'h05);
			@(posedge clk) req[i] <= 1'b1;
			repeat (4) @(posedge clk);
			req[i] <= 1'b0;
			wait_flag(2 + i, 1'b1);
			pulse_ack(2 + i);
			`CHK(flg[2 + i], 1'b0)
			wr_reg(8'h88, 8'h00);
			@(posedge clk) req[i] <= 1'b1;
			wait_flag(2 + i, 1'b1);
			pulse_ack(2 + i);
			`CHK(flg[2 + i], 1'b1)
			req[i] <= 1'b0;
			wait_flag(2 + i, 1'b0);
		end
		results();
	end
endmodule
